// File: hw/cmf_defs.vh
// constants of the clock mode and oscillator filter block
// assumes an 8-bit register port with a 3-bit word address
`ifndef CMF_DEFS_VH
`define CMF_DEFS_VH

`define CMF_AW 3
`define CMF_DW 8

// register offsets
`define CMF_OFS_FLAG 3'h0
`define CMF_OFS_IRQEN 3'h1
`define CMF_OFS_OSC 3'h2
`define CMF_OFS_CLKSEL 3'h3
`define CMF_OFS_POST_DIVIDER 3'h4
`define CMF_OFS_WDT 3'h5
`define CMF_OFS_RSTSRC 3'h6

// flag register fields
`define CMF_FLG_LOCKCHG 0
`define CMF_FLG_LOCK 1
`define CMF_FLG_OSCCHG 2
`define CMF_FLG_QUAL 3

// oscillator control fields
`define CMF_OSC_EN 0
`define CMF_OSC_BW 1
`define CMF_OSC_RATIO_LSB 2
`define CMF_OSC_RATIO_MSB 6

// clock select fields
`define CMF_CS_PLL_SELECT_BIT 0
`define CMF_CS_WDTOSC 1
`define CMF_CS_PITOSC 2

// reset values
`define CMF_POST_DIVIDER_RST 5'h03
`define CMF_PLL_SELECT_BIT_RST 1'b1
`define CMF_UNLOCK_DIV 5'h04

// timing counts: oscillator edges to qualify, relock time in vco clock cycles
`define CMF_QUAL_EDGES 4'h8
`define CMF_RELOCK_CYC 8'h40

// mode codes, one-hot
`define CMF_MODE_PEI 3'h1
`define CMF_MODE_PEE 3'h2
`define CMF_MODE_PBE 3'h4

`endif

// File: hw/cmf_osc_filter.v
// adaptive spike filter and noise detector for the crystal input
// assumes clk is the vco clock and crystal_input is synchronous to it
`include "cmf_defs.vh"

module cmf_osc_filter (
   clk,
   rst_n,
   crystal_input,
   filter_on,
   detect_on,
   ratio,
   wide,
   hold,
   clear_qual,
   osc_out,
   noise,
   qual
);
   input wire clk;
   input wire rst_n;
   input wire crystal_input;
   input wire filter_on;
   input wire detect_on;
   input wire [4:0] ratio;
   input wire wide;
   input wire hold;
   input wire clear_qual;
   output reg osc_out;
   output reg noise;
   output reg qual;

   reg [5:0] cnt_r;
   reg [3:0] good_r;

   // window edge: count reaches ratio-1, so the expected edge is ratio cycles after the last accepted one
   function [5:0] win_edge;
      input [4:0] r;
      input w;
      input hi;
      begin
         if (w && hi)
            win_edge = {1'b0, r};
         else if (w)
            win_edge = {1'b0, r} - 6'h02;
         else
            win_edge = {1'b0, r} - 6'h01;
      end
   endfunction

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_out <= 1'b0;
         noise <= 1'b0;
         qual <= 1'b0;
         cnt_r <= 6'h00;
         good_r <= 4'h0;
      end else if (!filter_on) begin
         osc_out <= crystal_input;
         noise <= 1'b0;
         qual <= 1'b0;
         cnt_r <= 6'h00;
         good_r <= 4'h0;
      end else if (hold) begin
         // output pauses while the vco restabilizes
         noise <= 1'b0;
      end else begin
         noise <= 1'b0;
         qual <= (good_r == `CMF_QUAL_EDGES) && !clear_qual;
         // sampled every vco cycle; early edges are spikes and simply ignored
         // a change past the window is not taken late, it falls to the noise branch
         if (crystal_input != osc_out && cnt_r >= win_edge(ratio, wide, 1'b0)
               && cnt_r <= win_edge(ratio, wide, 1'b1)) begin
            osc_out <= crystal_input;
            cnt_r <= 6'h00;
            if (clear_qual)
               good_r <= 4'h0;
            else if (good_r != `CMF_QUAL_EDGES)
               good_r <= good_r + 4'h1;
         end else if (cnt_r > win_edge(ratio, wide, 1'b1)) begin
            // no edge inside the window: noise that filtering cannot hide
            cnt_r <= 6'h00;
            good_r <= 4'h0;
            noise <= detect_on;
         end else begin
            cnt_r <= cnt_r + 6'h01;
            if (clear_qual)
               good_r <= 4'h0;
         end
      end
   end
endmodule

// File: hw/cmf_reset_src.v
// reset source gating and cause capture
// assumes all source inputs are synchronous levels, high while active
`include "cmf_defs.vh"

module cmf_reset_src (
   clk,
   rst_n,
   src_in,
   osc_enable,
   wdt_rate,
   cause_clear,
   sys_reset_req,
   cause
);
   input wire clk;
   input wire rst_n;
   input wire [5:0] src_in;
   input wire osc_enable;
   input wire [2:0] wdt_rate;
   input wire [5:0] cause_clear;
   output reg sys_reset_req;
   output reg [5:0] cause;

   // order: por, low voltage, pin, illegal address, clock monitor, watchdog
   wire [5:0] gated;
   assign gated = src_in & {(wdt_rate != 3'h0), osc_enable, 4'hf};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_req <= 1'b0;
         cause <= 6'h00;
      end else begin
         sys_reset_req <= |gated;
         // a new cause wins over a clear in the same cycle
         cause <= (cause & ~cause_clear) | gated;
      end
   end
endmodule

// File: hw/cmf_top.v
// clock mode control, oscillator qualification and reset sources
// assumes clk is the vco clock; pll lock detector and reset pins come in
// as synchronous levels, register port reads answer one cycle later
//
// Overview of operation
// - unfilterable noise clears qualified and lock, sets both change flags
// - while noise holds lock low, pll clock is vco divided by four
// - enabled filter samples crystal input every vco cycle
// - expected-edge window three vco cycles wide, else one cycle
// - ratio zero off; 2-3 narrow both; 2-3 wide filter; 4+ both
// - reset leaves internal-reference mode, post divider three
// - internal-reference mode clocks timers from the 1 MHz reference
// - external-reference mode: bus from pll, pll reference from oscillator
// - oscillator modes let timers pick reference or oscillator clock
// - losing lock also clears oscillator qualified status
// - bypassed mode losing qualification sets pll select automatically
// - bypassed mode oscillator and bus clock may pause during restabilizing
// - six reset sources; clock monitor and watchdog have local enables
// - lock change flag set on any lock change, write one clears
// - qualified zero while oscillator off; ratio zero qualifies after lock
// - oscillator change flag set on any qualified change
`include "cmf_defs.vh"

module cmf_top (
   clk,
   rst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   crystal_input,
   pll_locked_in,
   internal_reference_1mhz,
   por_in,
   low_voltage_reset,
   ext_pin_reset,
   illegal_addr_reset,
   clock_monitor_fail,
   watchdog_timeout,
   oscillator_clock,
   pll_output_clock,
   bus_clock_tick,
   bus_clk_from_pll,
   pll_ref_from_osc,
   mode_onehot,
   watchdog_clock,
   periodic_timer_clock,
   lock_status,
   osc_qualified,
   pll_lock_irq_enable,
   osc_status_irq_enable,
   sys_reset_req
);
   input wire clk;
   input wire rst_n;
   input wire [`CMF_AW-1:0] reg_addr;
   input wire [`CMF_DW-1:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [`CMF_DW-1:0] reg_rdata;
   input wire crystal_input;
   input wire pll_locked_in;
   input wire internal_reference_1mhz;
   input wire por_in;
   input wire low_voltage_reset;
   input wire ext_pin_reset;
   input wire illegal_addr_reset;
   input wire clock_monitor_fail;
   input wire watchdog_timeout;
   output wire oscillator_clock;
   output reg pll_output_clock;
   output reg bus_clock_tick;
   output wire bus_clk_from_pll;
   output wire pll_ref_from_osc;
   output wire [2:0] mode_onehot;
   output reg watchdog_clock;
   output reg periodic_timer_clock;
   output wire lock_status;
   output wire osc_qualified;
   output wire pll_lock_irq_enable;
   output wire osc_status_irq_enable;
   output wire sys_reset_req;

   localparam MODE_PEI = `CMF_MODE_PEI;
   localparam MODE_PEE = `CMF_MODE_PEE;
   localparam MODE_PBE = `CMF_MODE_PBE;

   // software-visible state
   reg lock_irq_en_r;
   reg osc_irq_en_r;
   reg osc_en_r;
   reg osc_bw_r;
   reg [4:0] ratio_r;
   reg pll_sel_r;
   reg wdt_osc_r;
   reg pit_osc_r;
   reg [4:0] post_divider_r;
   reg [2:0] wdt_rate_r;
   reg lock_flag_r;
   reg osc_flag_r;

   // hardware status
   reg lock_r;
   reg qual_r;
   reg noise_hold_r;
   reg [7:0] relock_cnt_r;
   reg [4:0] div_cnt_r;
   reg osc_prev_r;
   reg bus_phase_r;
   reg [2:0] mode_r;

   reg lock_nxt;
   reg qual_nxt;
   reg [2:0] mode_nxt;

   wire filt_osc;
   wire filt_noise;
   wire filt_qual;
   wire [5:0] rst_cause;
   wire wr_flag;
   wire wr_rst;
   wire filter_on;
   wire detect_on;
   wire osc_rise;
   wire [4:0] div_last;

   function is_wr;
      input [`CMF_AW-1:0] ofs;
      begin
         is_wr = reg_wr && (reg_addr == ofs);
      end
   endfunction

   assign wr_flag = is_wr(`CMF_OFS_FLAG);
   assign wr_rst = is_wr(`CMF_OFS_RSTSRC);

   // ratio 2..3 with wide window filters only; noise cannot be told apart
   assign filter_on = osc_en_r && (ratio_r != 5'h00);
   assign detect_on = (ratio_r >= 5'h04) || !osc_bw_r;

   cmf_osc_filter u_filter (
      .clk(clk),
      .rst_n(rst_n),
      .crystal_input(crystal_input),
      .filter_on(filter_on),
      .detect_on(detect_on),
      .ratio(ratio_r),
      .wide(osc_bw_r),
      .hold(!pll_locked_in && !pll_sel_r),
      .clear_qual(!lock_r),
      .osc_out(filt_osc),
      .noise(filt_noise),
      .qual(filt_qual)
   );

   cmf_reset_src u_reset (
      .clk(clk),
      .rst_n(rst_n),
      .src_in({watchdog_timeout, clock_monitor_fail, illegal_addr_reset,
               ext_pin_reset, low_voltage_reset, por_in}),
      .osc_enable(osc_en_r),
      .wdt_rate(wdt_rate_r),
      .cause_clear(wr_rst ? reg_wdata[5:0] : 6'h00),
      .sys_reset_req(sys_reset_req),
      .cause(rst_cause)
   );

   // lock and qualification status
   always @* begin
      lock_nxt = pll_locked_in && !noise_hold_r && !filt_noise;
      if (!osc_en_r)
         qual_nxt = 1'b0;
      else if (!lock_nxt)
         qual_nxt = 1'b0;
      else if (ratio_r == 5'h00)
         qual_nxt = lock_r;
      else
         qual_nxt = filt_qual;
   end

   always @* begin
      if (!osc_en_r)
         mode_nxt = MODE_PEI;
      else if (pll_sel_r)
         mode_nxt = MODE_PEE;
      else
         mode_nxt = MODE_PBE;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_r <= 1'b0;
         qual_r <= 1'b0;
         noise_hold_r <= 1'b0;
         relock_cnt_r <= 8'h00;
         mode_r <= MODE_PEI;
      end else begin
         lock_r <= lock_nxt;
         qual_r <= qual_nxt;
         mode_r <= mode_nxt;
         // after noise the lock stays down until the loop has settled again
         if (filt_noise) begin
            noise_hold_r <= 1'b1;
            relock_cnt_r <= 8'h00;
         end else if (noise_hold_r && pll_locked_in) begin
            if (relock_cnt_r == `CMF_RELOCK_CYC - 8'h01)
               noise_hold_r <= 1'b0;
            relock_cnt_r <= relock_cnt_r + 8'h01;
         end else begin
            relock_cnt_r <= 8'h00;
         end
      end
   end

   // change flags: a hardware set wins over a write-one clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_flag_r <= 1'b0;
         osc_flag_r <= 1'b0;
      end else begin
         if ((lock_nxt != lock_r) || filt_noise)
            lock_flag_r <= 1'b1;
         else if (wr_flag && reg_wdata[`CMF_FLG_LOCKCHG])
            lock_flag_r <= 1'b0;
         if ((qual_nxt != qual_r) || filt_noise)
            osc_flag_r <= 1'b1;
         else if (wr_flag && reg_wdata[`CMF_FLG_OSCCHG])
            osc_flag_r <= 1'b0;
      end
   end

   // control registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_irq_en_r <= 1'b0;
         osc_irq_en_r <= 1'b0;
         osc_en_r <= 1'b0;
         osc_bw_r <= 1'b0;
         ratio_r <= 5'h00;
         pll_sel_r <= `CMF_PLL_SELECT_BIT_RST;
         wdt_osc_r <= 1'b0;
         pit_osc_r <= 1'b0;
         post_divider_r <= `CMF_POST_DIVIDER_RST;
         wdt_rate_r <= 3'h0;
      end else begin
         if (is_wr(`CMF_OFS_IRQEN)) begin
            lock_irq_en_r <= reg_wdata[0];
            osc_irq_en_r <= reg_wdata[1];
         end
         if (is_wr(`CMF_OFS_OSC)) begin
            osc_en_r <= reg_wdata[`CMF_OSC_EN];
            osc_bw_r <= reg_wdata[`CMF_OSC_BW];
            ratio_r <= reg_wdata[`CMF_OSC_RATIO_MSB:`CMF_OSC_RATIO_LSB];
         end
         // losing qualification in bypass forces the bus back onto the pll
         if (mode_r == MODE_PBE && qual_r && !qual_nxt)
            pll_sel_r <= 1'b1;
         else if (is_wr(`CMF_OFS_CLKSEL))
            pll_sel_r <= reg_wdata[`CMF_CS_PLL_SELECT_BIT];
         if (is_wr(`CMF_OFS_CLKSEL)) begin
            wdt_osc_r <= reg_wdata[`CMF_CS_WDTOSC];
            pit_osc_r <= reg_wdata[`CMF_CS_PITOSC];
         end
         if (is_wr(`CMF_OFS_POST_DIVIDER))
            post_divider_r <= reg_wdata[4:0];
         if (is_wr(`CMF_OFS_WDT))
            wdt_rate_r <= reg_wdata[2:0];
      end
   end

   // pll output divider; unlocked output runs at vco over four
   assign div_last = lock_r ? post_divider_r : (`CMF_UNLOCK_DIV - 5'h01);
   assign osc_rise = filt_osc && !osc_prev_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 5'h00;
         pll_output_clock <= 1'b0;
         osc_prev_r <= 1'b0;
         bus_phase_r <= 1'b0;
         bus_clock_tick <= 1'b0;
         watchdog_clock <= 1'b0;
         periodic_timer_clock <= 1'b0;
      end else begin
         osc_prev_r <= filt_osc;
         if (div_cnt_r >= div_last) begin
            div_cnt_r <= 5'h00;
            pll_output_clock <= 1'b1;
         end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
            pll_output_clock <= 1'b0;
         end
         // bus runs at half the pll clock, or on the filtered oscillator
         // phase bit picks every other pll pulse, so the bus runs at pll over two
         if (pll_output_clock)
            bus_phase_r <= !bus_phase_r;
         if (pll_sel_r)
            bus_clock_tick <= pll_output_clock && bus_phase_r;
         else
            bus_clock_tick <= osc_rise;
         if (osc_en_r && wdt_osc_r)
            watchdog_clock <= osc_rise;
         else
            watchdog_clock <= internal_reference_1mhz;
         if (osc_en_r && pit_osc_r)
            periodic_timer_clock <= osc_rise;
         else
            periodic_timer_clock <= internal_reference_1mhz;
      end
   end

   // register read, data stands only in the cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `CMF_OFS_FLAG:
               reg_rdata <= {4'h0, qual_r, osc_flag_r, lock_r, lock_flag_r};
            `CMF_OFS_IRQEN:
               reg_rdata <= {6'h00, osc_irq_en_r, lock_irq_en_r};
            `CMF_OFS_OSC:
               reg_rdata <= {1'b0, ratio_r, osc_bw_r, osc_en_r};
            `CMF_OFS_CLKSEL:
               reg_rdata <= {5'h00, pit_osc_r, wdt_osc_r, pll_sel_r};
            `CMF_OFS_POST_DIVIDER:
               reg_rdata <= {3'h0, post_divider_r};
            `CMF_OFS_WDT:
               reg_rdata <= {5'h00, wdt_rate_r};
            `CMF_OFS_RSTSRC:
               reg_rdata <= {2'h0, rst_cause};
            default:
               reg_rdata <= 8'h00;
         endcase
      end
   end

   assign oscillator_clock = filt_osc;
   assign bus_clk_from_pll = pll_sel_r;
   assign pll_ref_from_osc = osc_en_r;
   assign mode_onehot = mode_r;
   assign lock_status = lock_r;
   assign osc_qualified = qual_r;
   // status interrupts belong to the system controller; enables only leave here
   assign pll_lock_irq_enable = lock_irq_en_r;
   assign osc_status_irq_enable = osc_irq_en_r;
endmodule

// File: test/cmf_top_asserts.sv
// checker for the clock mode block, sees only the top ports
// assumes the defs header is on the include path
`include "cmf_defs.vh"

module cmf_top_asserts (
   input logic clk,
   input logic rst_n,
   input logic internal_reference_1mhz,
   input logic por_in,
   input logic low_voltage_reset,
   input logic ext_pin_reset,
   input logic illegal_addr_reset,
   input logic clock_monitor_fail,
   input logic watchdog_timeout,
   input logic pll_output_clock,
   input logic bus_clk_from_pll,
   input logic pll_ref_from_osc,
   input logic [2:0] mode_onehot,
   input logic watchdog_clock,
   input logic periodic_timer_clock,
   input logic lock_status,
   input logic osc_qualified,
   input logic sys_reset_req
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // $past still sees reset values for a few edges after release
   logic [2:0] up_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_r <= 3'h0;
      end else if (up_r != 3'h7) begin
         up_r <= up_r + 3'h1;
      end
   end
   wire live = (up_r == 3'h7);
   // the first reset edge only launches the clear; values settle from the second
   logic rst_seen_r = 1'b0;
   always @(posedge clk) begin
      rst_seen_r <= !rst_n;
   end

   a_reset_state: assert property (disable iff (1'b0)
      !rst_n && rst_seen_r |-> mode_onehot == `CMF_MODE_PEI && bus_clk_from_pll)
      else $error("mode not internal reference during reset");
   a_unlock_div: assert property (
      (live && !lock_status)[*8] ##0 pll_output_clock
      |-> $past(pll_output_clock, 4) && !$past(pll_output_clock))
      else $error("unlocked pll clock not divided by four");
   a_qual_lock: assert property (!lock_status |-> !osc_qualified)
      else $error("qualified while unlocked");
   a_qual_off: assert property (
      !pll_ref_from_osc && !$past(pll_ref_from_osc) |-> !osc_qualified)
      else $error("qualified with oscillator off");
   a_bypass_exit: assert property (
      $fell(osc_qualified) && !bus_clk_from_pll && pll_ref_from_osc
      |-> ##[0:2] bus_clk_from_pll)
      else $error("pll select not restored after losing qualification");
   a_rst_src: assert property (
      por_in || low_voltage_reset || ext_pin_reset || illegal_addr_reset
      |=> sys_reset_req)
      else $error("ungated reset source ignored");
   a_rst_idle: assert property (
      !(por_in || low_voltage_reset || ext_pin_reset || illegal_addr_reset
      || clock_monitor_fail || watchdog_timeout) |=> !sys_reset_req)
      else $error("reset request without source");
   a_pee_route: assert property (
      mode_onehot == `CMF_MODE_PEE
      |-> $past(bus_clk_from_pll) && $past(pll_ref_from_osc))
      else $error("external reference mode with wrong routing");
   a_pbe_route: assert property (
      mode_onehot == `CMF_MODE_PBE
      |-> !$past(bus_clk_from_pll) && $past(pll_ref_from_osc))
      else $error("bypass mode with wrong routing");
   a_timer_ref: assert property (
      live && !pll_ref_from_osc && !$past(pll_ref_from_osc)
      |-> watchdog_clock == $past(internal_reference_1mhz)
      && periodic_timer_clock == $past(internal_reference_1mhz))
      else $error("timer clocks not from internal reference");

   c_lock: cover property ($rose(lock_status));
   c_bypass: cover property (mode_onehot == `CMF_MODE_PBE);
   c_reset_req: cover property ($rose(sys_reset_req));
endmodule

// File: test/cmf_top_tb_top.sv
// self-checking bench for cmf_top, register reads checked from a queue
// assumes the defs header is on the include path
`include "cmf_defs.vh"

module cmf_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic crystal_input = 1'b0;
   logic pll_locked_in = 1'b0;
   logic iref = 1'b0;
   logic [5:0] src = 6'h00;
   logic [16:0] lfsr = 17'h1_7ca0;
   logic rd_seen = 1'b0;
   logic prev;
   logic cx;
   logic [7:0] q[$];
   int fail_count = 0;
   int n_tests = 0;
   wire [7:0] reg_rdata;
   wire [2:0] mode_onehot;
   wire osc_clk, pll_clk, bus_tick, from_pll, ref_osc, qual, req;
   wire [1:0] irq_en;

   cmf_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .crystal_input(crystal_input), .pll_locked_in(pll_locked_in),
      .internal_reference_1mhz(iref), .por_in(src[0]), .low_voltage_reset(src[1]),
      .ext_pin_reset(src[2]), .illegal_addr_reset(src[3]), .clock_monitor_fail(src[4]),
      .watchdog_timeout(src[5]), .oscillator_clock(osc_clk), .pll_output_clock(pll_clk),
      .bus_clock_tick(bus_tick), .bus_clk_from_pll(from_pll), .pll_ref_from_osc(ref_osc),
      .mode_onehot(mode_onehot), .watchdog_clock(), .periodic_timer_clock(),
      .lock_status(), .osc_qualified(qual), .pll_lock_irq_enable(irq_en[0]),
      .osc_status_irq_enable(irq_en[1]), .sys_reset_req(req));

   always #50 clk = ~clk;

   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   always @(posedge clk) begin
      lfsr <= lfsr_next(lfsr);
      iref <= lfsr[0];
   end

   task automatic note(input logic [7:0] e, input logic [7:0] g, input string what);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
      note(e, g, "read");
   endtask
   task automatic cmp_sig(input logic [7:0] e, input logic [7:0] g);
      note(e, g, "pin");
   endtask

   always @(posedge clk) begin
      if (rd_seen) begin
         cmp_rd(q.pop_front(), reg_rdata);
      end
      rd_seen <= reg_rd;
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic count(input int n, input int e, input int eb);
      int k;
      int kb;
      k = 0;
      kb = 0;
      repeat (n) begin
         @(negedge clk);
         k += pll_clk;
         kb += bus_tick;
      end
      cmp_sig(8'(e), 8'(k));
      cmp_sig(8'(eb), 8'(kb));
   endtask
   // one oscillator half period of four clocks, optionally spent on a flag access
   task automatic half(input int op, input logic [7:0] d);
      crystal_input <= ~crystal_input;
      if (op == 1)
         wr(`CMF_OFS_FLAG, d);
      else if (op == 2)
         rd(`CMF_OFS_FLAG, d);
      else
         repeat (2) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   // one source pulse with a cleared cause register
   task automatic fire(input int i, input logic e);
      wr(`CMF_OFS_RSTSRC, 8'h3f);
      @(posedge clk);
      src <= 6'h01 << i;
      @(posedge clk);
      src <= 6'h00;
      @(negedge clk);
      cmp_sig({7'h00, e}, {7'h00, req});
      rd(`CMF_OFS_RSTSRC, e ? 8'h01 << i : 8'h00);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      $display("BAD %0t: timeout", $time);
      end_sim;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wt(1);
      cmp_sig({5'h00, `CMF_MODE_PEI}, {5'h00, mode_onehot});
      rd(`CMF_OFS_CLKSEL, 8'h01);
      rd(`CMF_OFS_POST_DIVIDER, 8'h03);
      rd(`CMF_OFS_WDT, 8'h00);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      wr(`CMF_OFS_IRQEN, 8'h03);
      rd(`CMF_OFS_IRQEN, 8'h03);
      cmp_sig(8'h03, {6'h00, irq_en});
      wr(`CMF_OFS_IRQEN, 8'h00);
      @(posedge clk);
      pll_locked_in <= 1'b1;
      wt(3);
      rd(`CMF_OFS_FLAG, 8'h03);
      wr(`CMF_OFS_FLAG, 8'h01);
      rd(`CMF_OFS_FLAG, 8'h02);
      wr(`CMF_OFS_OSC, 8'h01);
      wt(4);
      rd(`CMF_OFS_FLAG, 8'h0e);
      cmp_sig({5'h00, `CMF_MODE_PEE}, {5'h00, mode_onehot});
      wr(`CMF_OFS_FLAG, 8'h05);
      rd(`CMF_OFS_FLAG, 8'h0a);
      prev = crystal_input;
      repeat (24) begin
         @(posedge clk);
         cx = lfsr[5];
         crystal_input <= cx;
         @(negedge clk);
         cmp_sig({7'h00, prev}, {7'h00, osc_clk});
         prev = cx;
      end
      wr(`CMF_OFS_POST_DIVIDER, 8'h01);
      wt(4);
      count(40, 20, 10);
      wr(`CMF_OFS_CLKSEL, 8'h00);
      wt(2);
      cmp_sig({5'h00, `CMF_MODE_PBE}, {5'h00, mode_onehot});
      cmp_sig(8'h00, {7'h00, from_pll});
      @(posedge clk);
      pll_locked_in <= 1'b0;
      wt(4);
      cmp_sig(8'h01, {7'h00, from_pll});
      cmp_sig(8'h00, {7'h00, qual});
      rd(`CMF_OFS_FLAG, 8'h05);
      rd(`CMF_OFS_CLKSEL, 8'h01);
      wt(8);
      count(40, 10, 5);
      // filter at ratio four, narrow: qualify on eight good edges, then starve it
      @(posedge clk);
      pll_locked_in <= 1'b1;
      wr(`CMF_OFS_OSC, 8'h11);
      repeat (3) @(posedge clk);
      for (int k = 0; k < 14; k++) begin
         half(k == 10 ? 1 : (k == 12 ? 2 : 0), k == 10 ? 8'h05 : 8'h0a);
      end
      wt(2);
      rd(`CMF_OFS_FLAG, 8'h05);
      count(40, 10, 5);
      // ratio two, wide: filtering only, so a still crystal raises no noise
      wr(`CMF_OFS_OSC, 8'h0b);
      wt(80);
      rd(`CMF_OFS_FLAG, 8'h07);
      for (int i = 0; i < 6; i++) begin
         fire(i, i != 5);
      end
      wr(`CMF_OFS_WDT, 8'h02);
      fire(5, 1'b1);
      wr(`CMF_OFS_OSC, 8'h00);
      fire(4, 1'b0);
      end_sim;
   end
endmodule

bind cmf_top cmf_top_asserts i_chk (.clk, .rst_n, .internal_reference_1mhz, .por_in,
   .low_voltage_reset, .ext_pin_reset, .illegal_addr_reset, .clock_monitor_fail,
   .watchdog_timeout, .pll_output_clock, .bus_clk_from_pll, .pll_ref_from_osc,
   .mode_onehot, .watchdog_clock, .periodic_timer_clock, .lock_status, .osc_qualified,
   .sys_reset_req);
